// file: rtl/periph_regs_pkg.sv
package periph_regs_pkg;
  localparam int ADDR_W = 14;
  localparam int SLICE_BYTES = 16384;
  localparam int CTRL_SLICE_BYTES = 4096;
  localparam int NUM_PORTS = 2;
  localparam int NUM_CHAN = 4;
  localparam int STAT_W = 6;

  localparam logic [13:0] OFF_COMMAND = 14'h0000;
  localparam logic [13:0] OFF_CONFIG = 14'h0004;
  localparam logic [13:0] OFF_SHADOW_SET = 14'h0008;
  localparam logic [13:0] OFF_SHADOW_CLR = 14'h000C;
  localparam logic [13:0] OFF_SHADOW_STATE = 14'h0010;
  localparam logic [13:0] OFF_STATUS = 14'h0014;
  localparam logic [13:0] OFF_INT_ENABLE = 14'h0018;
  localparam logic [13:0] OFF_INT_DISABLE = 14'h001C;
  localparam logic [13:0] OFF_INT_MASK = 14'h0020;
  localparam logic [13:0] OFF_CHAN_BASE = 14'h0030;
  localparam logic [13:0] OFF_CHAN_STRIDE = 14'h0008;
  localparam logic [13:0] OFF_CHAN_CNT = 14'h0004;

  localparam logic [31:0] CONFIG_RESET = 32'h0000_0000;
  localparam logic [31:0] SHADOW_RESET = 32'h0000_0000;
  localparam logic [STAT_W-1:0] MASK_RESET = 6'h00;
  localparam logic [31:0] POINTER_RESET = 32'h0000_0000;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [31:0] XFER_SIZE = 32'h0000_0001;

  // command bits: status bit 0..3 are channel ends, 4 attention, 5 config written
  localparam int CMD_RAISE_ATTN = 0;
  localparam int CMD_CLEAR_ATTN = 1;
  localparam int ST_ATTN = 4;
  localparam int ST_CFG_WRITTEN = 5;

  typedef struct packed {
    logic [13:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } bus_req_t;

  typedef struct packed {
    logic [31:0] pointer;
    logic [15:0] count;
  } chan_t;
endpackage

// file: rtl/peripheral_register_interface.sv
// Design decisions made here: the address map and the plain strobed port.
module peripheral_register_interface
  import periph_regs_pkg::*;
#(
  parameter int SLICE = periph_regs_pkg::SLICE_BYTES
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic [31:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  input wire logic [periph_regs_pkg::NUM_CHAN-1:0] xfer_done,
  output logic [periph_regs_pkg::NUM_CHAN-1:0] chan_active,
  output logic [31:0] config_out,
  output logic [31:0] shadow_state,
  output logic irq
);
  import periph_regs_pkg::*;

  bus_req_t req;
  logic [31:0] config_reg;
  logic [STAT_W-1:0] status;
  logic [STAT_W-1:0] mask;
  chan_t chan [NUM_CHAN];
  logic [STAT_W-1:0] next_status;
  logic [STAT_W-1:0] status_set;

  assign req.addr = {addr[ADDR_W-1:2], 2'b00};
  assign req.wdata = wdata;
  assign req.wr = wr;
  assign req.rd = rd;

  wire w_cmd = req.wr && req.addr == OFF_COMMAND;
  wire w_cfg = req.wr && req.addr == OFF_CONFIG;
  wire w_set = req.wr && req.addr == OFF_SHADOW_SET;
  wire w_clr = req.wr && req.addr == OFF_SHADOW_CLR;
  wire w_ien = req.wr && req.addr == OFF_INT_ENABLE;
  wire w_idis = req.wr && req.addr == OFF_INT_DISABLE;

  function automatic logic hit_ptr(input logic [13:0] a, input int c);
    hit_ptr = a == 14'(OFF_CHAN_BASE + OFF_CHAN_STRIDE * 14'(c));
  endfunction

  function automatic logic hit_cnt(input logic [13:0] a, input int c);
    hit_cnt = a == 14'(OFF_CHAN_BASE + OFF_CHAN_STRIDE * 14'(c) + OFF_CHAN_CNT);
  endfunction

  wire raise_attn = w_cmd && req.wdata[CMD_RAISE_ATTN];
  wire clear_attn = w_cmd && req.wdata[CMD_CLEAR_ATTN];

  always_ff @(posedge clk) begin
    if (reset) begin
      config_reg <= CONFIG_RESET;
    end else if (clk_en && w_cfg) begin
      config_reg <= req.wdata;
    end
  end

  // set and clear of shadow state
  always_ff @(posedge clk) begin
    if (reset) begin
      shadow_state <= SHADOW_RESET;
    end else if (clk_en && (w_set || w_clr)) begin
      shadow_state <= w_set ? (shadow_state | req.wdata) : (shadow_state & ~req.wdata);
    end
  end

  genvar g;
  generate
    for (g = 0; g < NUM_CHAN; g++) begin : g_chan
      wire w_ptr = req.wr && hit_ptr(req.addr, g);
      wire w_cnt = req.wr && hit_cnt(req.addr, g);
      wire step = xfer_done[g] && chan[g].count != 16'h0000;
      assign chan_active[g] = chan[g].count != 16'h0000;
      // end flag when count reaches zero
      assign status_set[g] = step && chan[g].count == 16'h0001;
      always_ff @(posedge clk) begin
        if (reset) begin
          chan[g] <= '{POINTER_RESET, COUNT_RESET};
        end else if (clk_en) begin
          if (w_ptr) begin
            chan[g].pointer <= req.wdata;
          end else if (step) begin
            chan[g].pointer <= chan[g].pointer + XFER_SIZE;
          end
          if (w_cnt) begin
            chan[g].count <= req.wdata[15:0];
          end else if (step) begin
            chan[g].count <= chan[g].count - 16'h0001;
          end
        end
      end
    end
  endgenerate

  assign status_set[ST_ATTN] = raise_attn;
  assign status_set[ST_CFG_WRITTEN] = w_cfg;

  // status set only by events and commands, never by a STATUS write; set wins over command clear
  always_comb begin
    next_status = status;
    if (clear_attn) begin
      next_status[ST_ATTN] = 1'b0;
    end
    next_status = next_status | status_set;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      status <= '0;
    end else if (clk_en) begin
      status <= next_status;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      mask <= MASK_RESET;
    end else if (clk_en) begin
      if (w_ien) begin
        mask <= mask | req.wdata[STAT_W-1:0];
      end else if (w_idis) begin
        mask <= mask & ~req.wdata[STAT_W-1:0];
      end
    end
  end

  assign irq = |(status & mask);
  assign config_out = config_reg;

  // unused bits and unmapped read zero
  logic [31:0] read_mux;
  always_comb begin
    read_mux = 32'h0000_0000;
    if (req.addr == OFF_CONFIG) read_mux = config_reg;
    if (req.addr == OFF_SHADOW_STATE) read_mux = shadow_state;
    if (req.addr == OFF_STATUS) read_mux = {26'h0, status};
    if (req.addr == OFF_INT_MASK) read_mux = {26'h0, mask};
    for (int c = 0; c < NUM_CHAN; c++) begin
      if (hit_ptr(req.addr, c)) read_mux = chan[c].pointer;
      if (hit_cnt(req.addr, c)) read_mux = {16'h0000, chan[c].count};
    end
  end

  // full word read, one cycle later
  always_ff @(posedge clk) begin
    if (reset) begin
      rdata <= 32'h0000_0000;
    end else if (clk_en) begin
      rdata <= req.rd ? read_mux : 32'h0000_0000;
    end
  end
endmodule // peripheral_register_interface

// file: tb/periph_regs_sva.sv
module periph_regs_sva (
  input wire logic clk,
  input wire logic reset,
  input wire logic [31:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [31:0] rdata,
  input wire logic [3:0] chan_active,
  input wire logic [31:0] config_out,
  input wire logic [31:0] shadow_state,
  input wire logic irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // low two bits ignored, so idx is the word number
  wire logic [11:0] idx = addr[13:2];
  AST_CFG_WR: assert property (wr && idx == 1 |=> config_out == $past(wdata))
    else $error("config write lost");
  AST_CFG_HOLD: assert property (!(wr && idx == 1) |=> $stable(config_out))
    else $error("config changed");
  AST_SET: assert property (wr && idx == 2 |=> (shadow_state & $past(wdata)) == $past(wdata))
    else $error("set failed");
  AST_CLR: assert property (wr && idx == 3 |=> (shadow_state & $past(wdata)) == 0)
    else $error("clear failed");
  AST_KEEP: assert property (wr && idx == 2 |=> (shadow_state & ~$past(wdata)) ==
    ($past(shadow_state) & ~$past(wdata))) else $error("state bits disturbed");
  AST_MASKED: assert property (rd && idx == 8 ##1 rdata[5:0] == 0 |-> !irq)
    else $error("irq with empty mask");
  AST_UNMAPPED: assert property (rd && idx > 19 |=> rdata == 0)
    else $error("unmapped read nonzero");
  AST_ACTIVE: assert property (wr && idx == 13 && wdata[15:0] != 0 |=> chan_active[0])
    else $error("channel idle");
  cover property (irq);
  cover property (wr && idx == 2);
  cover property (rd ##1 rdata != 0);
endmodule // periph_regs_sva

bind peripheral_register_interface periph_regs_sva chk_u (.*);

// file: tb/cpu_model.sv
module cpu_model (
  input wire logic clk,
  input wire logic [31:0] rdata,
  output logic [31:0] addr,
  output logic [31:0] wdata,
  output logic wr,
  output logic rd
);
  timeunit 1ns;
  timeprecision 1ps;
  initial {addr, wdata, wr, rd} = '0;
  task automatic put(input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'h1;
    @(posedge clk);
    wr <= 1'h0;
  endtask
  task automatic get(input logic [31:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'h1;
    @(posedge clk);
    rd <= 1'h0;
    #1 d = rdata;
  endtask
endmodule // cpu_model

// file: tb/tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, reset, wr, rd, irq;
  logic [3:0] xfer_done, chan_active;
  logic [31:0] addr, wdata, rdata, got, config_seen, state_seen;
  int err_total, tests_run;
  // write address, data, read address, expected
  logic [15:0] rows [8][4] = '{
    '{16'h001C, 16'h003F, 16'h0020, 16'h0000},
    '{16'h0004, 16'h1234, 16'h0004, 16'h1234},
    '{16'h0014, 16'hFFFF, 16'h0014, 16'h0020},
    '{16'h0008, 16'h00F0, 16'h0010, 16'h00F0},
    '{16'h000C, 16'h0030, 16'h0010, 16'h00C0},
    '{16'h0018, 16'h0011, 16'h0020, 16'h0011},
    '{16'h003A, 16'hCAFE, 16'h0038, 16'hCAFE},
    '{16'h0200, 16'h0005, 16'h0200, 16'h0000}};
  cpu_model cpu_u (.clk(clk), .rdata(rdata), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd));
  peripheral_register_interface dut_u (.clk(clk), .reset(reset), .clk_en(1'h1), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .xfer_done(xfer_done),
    .chan_active(chan_active), .config_out(config_seen), .shadow_state(state_seen), .irq(irq));
  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic rdchk(string n, logic [31:0] a, logic [31:0] e);
    cpu_u.get(a, got);
    chk(n, e, got);
  endtask
  task automatic step(int c);
    @(posedge clk);
    xfer_done[c] <= 1'h1;
    @(posedge clk);
    xfer_done <= 4'h0;
  endtask
  task automatic complete_run;
    $display("mismatches %0d of %0d checks", err_total, tests_run);
    if (err_total == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // a hang is cut short here
  initial begin
    #200us;
    err_total++;
    complete_run();
  end
  initial begin
    reset = 1'h1;
    xfer_done = 4'h0;
    repeat (12) @(posedge clk);
    reset <= 1'h0;
    rdchk("config", 32'h0000_0004, 32'h0000_0000);
    foreach (rows[i]) begin
      cpu_u.put({16'h0000, rows[i][0]}, {16'h0000, rows[i][1]});
      rdchk("row", {16'h0000, rows[i][2]}, {16'h0000, rows[i][3]});
    end
    chk("config_out", 32'h0000_1234, config_seen);
    chk("shadow_state", 32'h0000_00C0, state_seen);
    cpu_u.put(32'h0000_0018, 32'h0000_0010);
    cpu_u.put(32'h0000_0000, 32'h0000_0001);
    #1 chk("irq", 32'h0000_0001, irq);
    cpu_u.put(32'h0000_001C, 32'h0000_0010);
    #1 chk("irq", 32'h0000_0000, irq);
    cpu_u.put(32'h0000_0000, 32'h0000_0000);
    rdchk("status", 32'h0000_0014, 32'h0000_0030);
    cpu_u.put(32'h0000_0000, 32'h0000_0002);
    cpu_u.put(32'h0000_0034, 32'h0000_0002);
    #1 chk("chan_active", 32'h0000_0001, chan_active);
    // third completion lands on an empty counter and is ignored
    repeat (3) step(0);
    rdchk("pointer", 32'h0000_0030, 32'h0000_0002);
    rdchk("count", 32'h0000_0034, 32'h0000_0000);
    rdchk("status", 32'h0000_0014, 32'h0000_0021);
    chk("irq", 32'h0000_0001, irq);
    chk("chan_active", 32'h0000_0000, chan_active);
    complete_run();
  end
endmodule // tb_top
